/* design/phase_accumulator_oscillator.sv */
// Register access over AHB-Lite was decided locally.
`timescale 1ns/10ps
`include "pao_defs.svh"
module phase_accumulator_oscillator
   import pao_pkg::*;
(
   input wire logic mclk, // System clock, 20 MHz.
   input wire logic nrst, // Asynchronous reset, active low.
   input wire logic hsel, // AHB slave select.
   input wire logic [31:0] haddr, // AHB address.
   input wire logic [1:0] htrans, // AHB transfer type.
   input wire logic hwrite, // AHB write flag.
   input wire logic [2:0] hsize, // AHB transfer size.
   input wire logic [31:0] hwdata, // AHB write data.
   input wire logic hready, // AHB bus ready.
   output logic hreadyout, // Slave ready, always high.
   output logic hresp, // Slave response, always OKAY.
   output logic [31:0] hrdata, // Read data.
   input wire logic [15:0] srcClk, // Candidate accumulation clocks.
   output logic synthSignal, // Final oscillator output.
   output logic irqReq, // Interrupt service request.
   output logic fastOscHold // Keep fast oscillator on in sleep.
);

   // ----------------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------------
   pao_ctrl_t ctrl_reg;
   pao_clksel_t clkSel_reg;
   pao_irq_t irq_reg;
   logic [19:0] phase_reg;
   logic [19:0] step_reg;
   logic [19:0] stepShadow_reg;
   logic [1:0] pend_reg;
   logic loadNow_reg;
   logic toggle_reg;
   logic [7:0] pulseCnt_reg;
   logic carry_reg;
   logic dphWrite_reg;
   logic [13:0] dphIdx_reg;
   logic [20:0] sum;
   logic tick;
   logic wrEn;
   logic [7:0] wrByte;
   logic [7:0] widthTicks;
   logic levelNext;
   logic invertFlip;

   // ----------------------------------------------------------------------
   // Source clock synchronisers
   // ----------------------------------------------------------------------
   logic [15:0] srcRise;

   // Each candidate clock passes three flops; the filtered level changes
   // only when the second and third stages agree, which rejects a single
   // metastable sample at the cost of three cycles of latency.
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi = gi + 1) begin : g_sync
         logic s1_reg;
         logic s2_reg;
         logic s3_reg;
         logic lvl_reg;
         always_ff @(posedge mclk or negedge nrst) begin
            if (!nrst) begin
               s1_reg <= 1'b0;
               s2_reg <= 1'b0;
               s3_reg <= 1'b0;
               lvl_reg <= 1'b0;
            end else begin
               s1_reg <= srcClk[gi];
               s2_reg <= s1_reg;
               s3_reg <= s2_reg;
               if (s2_reg == s3_reg) begin
                  lvl_reg <= s3_reg;
               end
            end
         end
         assign srcRise[gi] = (s2_reg == s3_reg) && s3_reg && !lvl_reg;
      end
   endgenerate

   // Source zero is the system clock itself, so it ticks every cycle;
   // code 15 is reserved and never ticks.
   always_comb begin
      if (clkSel_reg.clockSourceSelect == `PAO_SRC_SYSCLK) begin
         tick = 1'b1;
      end else if (clkSel_reg.clockSourceSelect == `PAO_SRC_RESERVED) begin
         tick = 1'b0;
      end else begin
         tick = srcRise[clkSel_reg.clockSourceSelect];
      end
   end

   // ----------------------------------------------------------------------
   // AHB-Lite slave
   // ----------------------------------------------------------------------
   // Zero wait states: every transfer completes in its first data cycle.
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign wrEn = dphWrite_reg;
   assign wrByte = hwdata[7:0];

   // Address phase capture for the following write data phase.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         dphWrite_reg <= 1'b0;
         dphIdx_reg <= 14'h0000;
      end else begin
         dphWrite_reg <= hsel && hready && htrans[`PAO_HTRANS_NONSEQ_BIT]
                         && hwrite;
         dphIdx_reg <= haddr[15:2];
      end
   end

   // Read data is sampled at the address phase edge. A read issued right
   // behind a write to the same register returns the value before it.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         hrdata <= 32'h00000000;
      end else if (hsel && hready && htrans[`PAO_HTRANS_NONSEQ_BIT]
                   && !hwrite) begin
         hrdata <= 32'h00000000;
         unique case (haddr[15:2])
            `PAO_IDX_PHASE_LO: hrdata[7:0] <= phase_reg[7:0];
            `PAO_IDX_PHASE_HI: hrdata[7:0] <= phase_reg[15:8];
            `PAO_IDX_PHASE_UP: hrdata[3:0] <= phase_reg[19:16];
            `PAO_IDX_STEP_LO: hrdata[7:0] <= step_reg[7:0];
            `PAO_IDX_STEP_HI: hrdata[7:0] <= step_reg[15:8];
            `PAO_IDX_STEP_UP: hrdata[3:0] <= step_reg[19:16];
            `PAO_IDX_CONTROL: begin
               hrdata[`PAO_CON_EN] <= ctrl_reg.enable;
               hrdata[`PAO_CON_OUT] <= synthSignal;
               hrdata[`PAO_CON_INV] <= ctrl_reg.invertSelect;
               hrdata[`PAO_CON_PULSE] <= ctrl_reg.pulseFrequencySelect;
            end
            `PAO_IDX_CLOCK: begin
               hrdata[`PAO_CLK_WIDTH_HI:`PAO_CLK_WIDTH_LO] <=
                  clkSel_reg.pulseWidthSelect;
               hrdata[`PAO_CLK_SRC_HI:`PAO_CLK_SRC_LO] <=
                  clkSel_reg.clockSourceSelect;
            end
            `PAO_IDX_IRQ: hrdata[3:0] <= irq_reg;
            default: hrdata <= 32'h00000000;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Control and step registers
   // ----------------------------------------------------------------------
   // Software-written configuration; every field resets to zero.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ctrl_reg <= '0;
         clkSel_reg <= '0;
         step_reg <= `PAO_RST_PHASE;
      end else if (wrEn) begin
         unique case (dphIdx_reg)
            `PAO_IDX_CONTROL: begin
               ctrl_reg.enable <= wrByte[`PAO_CON_EN];
               ctrl_reg.invertSelect <= wrByte[`PAO_CON_INV];
               ctrl_reg.pulseFrequencySelect <= wrByte[`PAO_CON_PULSE];
            end
            `PAO_IDX_CLOCK: begin
               clkSel_reg.pulseWidthSelect <=
                  wrByte[`PAO_CLK_WIDTH_HI:`PAO_CLK_WIDTH_LO];
               clkSel_reg.clockSourceSelect <=
                  wrByte[`PAO_CLK_SRC_HI:`PAO_CLK_SRC_LO];
            end
            `PAO_IDX_STEP_LO: step_reg[7:0] <= wrByte;
            `PAO_IDX_STEP_HI: step_reg[15:8] <= wrByte;
            `PAO_IDX_STEP_UP: step_reg[19:16] <= wrByte[3:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Step shadow double buffer
   // ----------------------------------------------------------------------
   // The low-byte write arms a two-tick countdown while running; the upper
   // bytes must already be in place, since the whole word is committed.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pend_reg <= `PAO_PEND_IDLE;
         loadNow_reg <= 1'b0;
         stepShadow_reg <= `PAO_RST_PHASE;
      end else begin
         loadNow_reg <= wrEn && !ctrl_reg.enable
                        && (dphIdx_reg == `PAO_IDX_STEP_LO
                         || dphIdx_reg == `PAO_IDX_STEP_HI
                         || dphIdx_reg == `PAO_IDX_STEP_UP);
         if (wrEn && ctrl_reg.enable && dphIdx_reg == `PAO_IDX_STEP_LO) begin
            pend_reg <= `PAO_PEND_START;
         end else if (tick && pend_reg != `PAO_PEND_IDLE) begin
            pend_reg <= pend_reg - `PAO_PEND_LAST;
         end
         if (loadNow_reg) begin
            stepShadow_reg <= step_reg;
         end else if (tick && pend_reg == `PAO_PEND_LAST) begin
            stepShadow_reg <= step_reg;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Phase accumulator
   // ----------------------------------------------------------------------
   assign sum = {1'b0, phase_reg} + {1'b0, stepShadow_reg};

   // Full adder on every tick while enabled; the carry drops off and the low twenty bits
   // keep the residue, so long-term frequency stays exact.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         phase_reg <= `PAO_RST_PHASE;
         carry_reg <= 1'b0;
      end else begin
         carry_reg <= 1'b0;
         if (wrEn && dphIdx_reg == `PAO_IDX_PHASE_LO) begin
            phase_reg[7:0] <= wrByte;
         end else if (wrEn && dphIdx_reg == `PAO_IDX_PHASE_HI) begin
            phase_reg[15:8] <= wrByte;
         end else if (wrEn && dphIdx_reg == `PAO_IDX_PHASE_UP) begin
            phase_reg[19:16] <= wrByte[3:0];
         end else if (tick && ctrl_reg.enable) begin
            phase_reg <= sum[19:0];
            carry_reg <= sum[20];
         end
      end
   end

   // ----------------------------------------------------------------------
   // Output shaping
   // ----------------------------------------------------------------------
   assign widthTicks = `PAO_WIDTH_ONE << clkSel_reg.pulseWidthSelect;

   // The carry is seen one cycle after the adding tick, so the pulse
   // starts on the edge after the overflow. A new carry reloads the count,
   // which keeps the output active when pulses overlap.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         toggle_reg <= 1'b0;
         pulseCnt_reg <= `PAO_RST_WIDTH;
      end else begin
         if (carry_reg && !ctrl_reg.pulseFrequencySelect) begin
            toggle_reg <= !toggle_reg;
         end
         if (carry_reg && ctrl_reg.pulseFrequencySelect) begin
            pulseCnt_reg <= widthTicks;
         end else if (tick && pulseCnt_reg != `PAO_RST_WIDTH) begin
            pulseCnt_reg <= pulseCnt_reg - `PAO_WIDTH_ONE;
         end
      end
   end

   assign levelNext = (ctrl_reg.pulseFrequencySelect ?
                       (pulseCnt_reg != `PAO_RST_WIDTH) : toggle_reg)
                      ^ ctrl_reg.invertSelect;

   // Registered final stage, routed to the other peripherals.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         synthSignal <= 1'b0;
      end else begin
         synthSignal <= levelNext;
      end
   end

   // ----------------------------------------------------------------------
   // Interrupt bits and side outputs
   // ----------------------------------------------------------------------
   assign invertFlip = wrEn && dphIdx_reg == `PAO_IDX_CONTROL
                       && (wrByte[`PAO_CON_INV] != ctrl_reg.invertSelect);

   // A hardware set in the same cycle as a software clear wins, so no
   // carry is lost. Writing one to the flag bit leaves it untouched.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         irq_reg <= '0;
      end else begin
         if (wrEn && dphIdx_reg == `PAO_IDX_IRQ) begin
            irq_reg.carryIrqEnable <= wrByte[`PAO_IRQ_IE];
            irq_reg.periphEnable <= wrByte[`PAO_IRQ_PIE];
            irq_reg.globalEnable <= wrByte[`PAO_IRQ_GIE];
         end
         if (carry_reg || (invertFlip && irq_reg.carryIrqEnable)) begin
            irq_reg.carryIrqFlag <= 1'b1;
         end else if (wrEn && dphIdx_reg == `PAO_IDX_IRQ
                      && !wrByte[`PAO_IRQ_FLAG]) begin
            irq_reg.carryIrqFlag <= 1'b0;
         end
      end
   end

   assign irqReq = irq_reg.carryIrqFlag && ctrl_reg.enable
                   && irq_reg.carryIrqEnable && irq_reg.periphEnable
                   && irq_reg.globalEnable;
   assign fastOscHold = ctrl_reg.enable
      && clkSel_reg.clockSourceSelect == `PAO_SRC_FASTOSC;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   phase_add_a: assert property (tick && ctrl_reg.enable && !wrEn
      |=> phase_reg == $past(sum[19:0]))
      else $error("Accumulator did not add the shadow step.");
   carry_event_a: assert property (tick && ctrl_reg.enable && !wrEn
      && sum[20] |=> carry_reg)
      else $error("Carry not raised on overflow.");
   stop_hold_a: assert property (!ctrl_reg.enable && !wrEn
      |=> $stable(phase_reg))
      else $error("Accumulator moved while disabled.");
   shadow_late_a: assert property (wrEn && ctrl_reg.enable
      && dphIdx_reg == `PAO_IDX_STEP_LO && !tick
      |=> pend_reg == `PAO_PEND_START && $stable(stepShadow_reg))
      else $error("Shadow loaded too early after low-byte write.");
   shadow_second_a: assert property (tick && pend_reg == `PAO_PEND_LAST
      && !loadNow_reg && !wrEn |=> stepShadow_reg == $past(step_reg))
      else $error("Shadow missed its second tick load.");
   shadow_now_a: assert property (wrEn && !ctrl_reg.enable
      && dphIdx_reg == `PAO_IDX_STEP_HI ##1 !wrEn
      |=> stepShadow_reg == $past(step_reg))
      else $error("Disabled step write did not load shadow.");
   toggle_flip_a: assert property (carry_reg
      && !ctrl_reg.pulseFrequencySelect |=> toggle_reg != $past(toggle_reg))
      else $error("Toggle mode missed a carry.");
   pulse_load_a: assert property (carry_reg
      && ctrl_reg.pulseFrequencySelect |=> pulseCnt_reg == $past(widthTicks))
      else $error("Pulse width not loaded on carry.");
   pulse_active_a: assert property (ctrl_reg.pulseFrequencySelect
      && !ctrl_reg.invertSelect && pulseCnt_reg != `PAO_RST_WIDTH
      && $stable(ctrl_reg) |=> synthSignal)
      else $error("Pulse output not active during its width.");
   flag_set_a: assert property (carry_reg |=> irq_reg.carryIrqFlag)
      else $error("Carry did not set the flag.");
   invert_irq_a: assert property (invertFlip && irq_reg.carryIrqEnable
      |=> irq_reg.carryIrqFlag)
      else $error("Polarity change did not raise the flag.");
   flag_sticky_a: assert property (irq_reg.carryIrqFlag
      && !(wrEn && dphIdx_reg == `PAO_IDX_IRQ) |=> irq_reg.carryIrqFlag)
      else $error("Flag cleared without a software write.");
   irq_gate_a: assert property (irqReq |-> ctrl_reg.enable
      && irq_reg.globalEnable && irq_reg.periphEnable)
      else $error("Request raised with an enable cleared.");
   upper_zero_a: assert property (hsel && hready && !hwrite
      && htrans[`PAO_HTRANS_NONSEQ_BIT] && haddr[15:2] == `PAO_IDX_STEP_UP
      |=> hrdata[31:4] == 28'h0000000)
      else $error("Upper step byte reads nonzero high bits.");

   carry_seen_c: cover property (carry_reg ##[1:300] carry_reg);
   pulse_overlap_c: cover property (carry_reg
      && pulseCnt_reg != `PAO_RST_WIDTH);
   shadow_load_c: cover property (tick && pend_reg == `PAO_PEND_LAST);
   irq_req_c: cover property ($rose(irqReq));

endmodule

/* design/pao_defs.svh */
`ifndef PAO_DEFS_SVH
`define PAO_DEFS_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define PAO_IDX_PHASE_LO 14'h058C
`define PAO_IDX_PHASE_HI 14'h058D
`define PAO_IDX_PHASE_UP 14'h058E
`define PAO_IDX_STEP_LO 14'h058F
`define PAO_IDX_STEP_HI 14'h0590
`define PAO_IDX_STEP_UP 14'h0591
`define PAO_IDX_CONTROL 14'h0592
`define PAO_IDX_CLOCK 14'h0593
`define PAO_IDX_IRQ 14'h0594

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define PAO_CON_EN 7
`define PAO_CON_OUT 5
`define PAO_CON_INV 4
`define PAO_CON_PULSE 0
`define PAO_CLK_WIDTH_HI 7
`define PAO_CLK_WIDTH_LO 5
`define PAO_CLK_SRC_HI 3
`define PAO_CLK_SRC_LO 0
`define PAO_IRQ_FLAG 0
`define PAO_IRQ_IE 1
`define PAO_IRQ_PIE 2
`define PAO_IRQ_GIE 3
`define PAO_RST_BYTE 8'h00
`define PAO_RST_PHASE 20'h00000
`define PAO_RST_WIDTH 8'h00
`define PAO_WIDTH_ONE 8'h01
`define PAO_PEND_START 2'h2
`define PAO_PEND_LAST 2'h1
`define PAO_PEND_IDLE 2'h0
`define PAO_SRC_SYSCLK 4'h0
`define PAO_SRC_FASTOSC 4'h1
`define PAO_SRC_RESERVED 4'hF
`define PAO_HTRANS_NONSEQ_BIT 1

`endif

/* design/pao_pkg.sv */
package pao_pkg;

   // Control byte as software sees it.
   typedef struct packed {
      logic enable;
      logic invertSelect;
      logic pulseFrequencySelect;
   } pao_ctrl_t;

   // Clock byte: pulse width and source selection.
   typedef struct packed {
      logic [2:0] pulseWidthSelect;
      logic [3:0] clockSourceSelect;
   } pao_clksel_t;

   // Interrupt-side bits.
   typedef struct packed {
      logic globalEnable;
      logic periphEnable;
      logic carryIrqEnable;
      logic carryIrqFlag;
   } pao_irq_t;

endpackage

/* tb/pao_sink.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// Peripheral that consumes the routed oscillator output
// ----------------------------------------------------------------------
module pao_sink (
   input wire logic mclk, // System clock.
   input wire logic nrst, // Reset, active low.
   input wire logic clr, // Clears the edge count.
   input wire logic sig, // Routed oscillator output.
   output logic [15:0] rises, // Rising edges since the last clear.
   output logic [15:0] lastHigh, // Cycles of the last high phase.
   output logic [15:0] lastLow // Cycles of the last low phase.
);
   logic prev;
   logic [15:0] run;
   // A consumer samples only on mclk, so phases are counted in cycles.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         prev <= 1'b0;
         run <= 16'h0000;
         rises <= 16'h0000;
         lastHigh <= 16'h0000;
         lastLow <= 16'h0000;
      end else begin
         prev <= sig;
         run <= (sig == prev) ? run + 16'h0001 : 16'h0001;
         if (sig && !prev) lastLow <= run;
         if (!sig && prev) lastHigh <= run;
         rises <= clr ? 16'h0000 : rises + {15'h0000, sig && !prev};
      end
   end
endmodule

/* tb/test_phase_accumulator_oscillator.sv */
`timescale 1ns/10ps
`include "pao_defs.svh"
module test_phase_accumulator_oscillator;
   import pao_pkg::*;
   logic mclk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0, clr = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, q;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2, div = 3'h0;
   logic [15:0] srcClk = 16'h0000, rises, lastHigh, lastLow, r;
   wire logic hready, hresp, synthSignal, irqReq, fastOscHold;
   wire logic [31:0] hrdata;
   int num_errors = 0, comparisons = 0;
   // ------------------------------------------------------------------
   // Clock, slow source and the parts
   // ------------------------------------------------------------------
   always #25 mclk = ~mclk;
   // Source 2 is high four cycles and low four, above the minimum two.
   always @(posedge mclk) begin
      div <= div + 3'h1;
      srcClk <= {13'h0000, div[2], 2'b00};
   end
   phase_accumulator_oscillator dut_u (.mclk(mclk), .nrst(nrst),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
      .srcClk(srcClk), .synthSignal(synthSignal), .irqReq(irqReq),
      .fastOscHold(fastOscHold));
   pao_sink sink_u (.mclk(mclk), .nrst(nrst), .clr(clr),
      .sig(synthSignal), .rises(rises), .lastHigh(lastHigh),
      .lastLow(lastLow));
   // ------------------------------------------------------------------
   // Bus cycles and helpers
   // ------------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] s, e);
      comparisons++;
      if (s !== e) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   // Address phase held until hready, then the data phase likewise.
   task automatic xfer(input logic [13:0] ix, input logic w,
                       input logic [7:0] d);
      @(posedge mclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {16'h0000, ix, 2'b00};
      do @(posedge mclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h000000, d};
      do @(posedge mclk); while (hready !== 1'b1);
      q = hrdata;
   endtask
   // Return at the falling edge, so that combinational outputs that the
   // write has just changed are settled before anyone looks at them.
   task automatic wr(input logic [13:0] ix, input logic [7:0] d);
      xfer(ix, 1'b1, d);
      @(negedge mclk);
   endtask
   task automatic rd(input logic [13:0] ix);
      xfer(ix, 1'b0, 8'h00);
   endtask
   // Counts rising edges of the output over n cycles.
   task automatic cnt(input int n);
      clr <= 1'b1;
      @(posedge mclk);
      clr <= 1'b0;
      repeat (n) @(posedge mclk);
      r = rises;
   endtask
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task automatic t_reset;
      for (int i = 0; i < 10; i++) begin
         rd(`PAO_IDX_PHASE_LO + i[13:0]);
         chk("reset read", q, 32'h0);
      end
      chk("hresp", {31'h0, hresp}, 32'h0);
      $display("test reset done");
   endtask
   task automatic t_regs;
      wr(`PAO_IDX_STEP_UP, 8'hFF);
      rd(`PAO_IDX_STEP_UP);
      chk("step upper", q, 32'h0F);
      wr(`PAO_IDX_PHASE_UP, 8'hFF);
      rd(`PAO_IDX_PHASE_UP);
      chk("phase upper", q, 32'h0F);
      wr(`PAO_IDX_STEP_HI, 8'hA5);
      rd(`PAO_IDX_STEP_HI);
      chk("step high", q, 32'hA5);
      $display("test registers done");
   endtask
   // Step 0x60000 gives three carries per eight ticks: residue matters.
   task automatic t_toggle;
      wr(`PAO_IDX_STEP_UP, 8'h06);
      wr(`PAO_IDX_STEP_HI, 8'h00);
      wr(`PAO_IDX_STEP_LO, 8'h00);
      wr(`PAO_IDX_CONTROL, 8'h80);
      cnt(800);
      chk("toggle", {31'h0, r >= 149 && r <= 151}, 32'h1);
      wr(`PAO_IDX_CONTROL, 8'h00);
      rd(`PAO_IDX_PHASE_UP);
      r = q[15:0];
      repeat (40) @(posedge mclk);
      rd(`PAO_IDX_PHASE_UP);
      chk("stopped", q, {16'h0, r});
      $display("test toggle done");
   endtask
   task automatic t_commit;
      wr(`PAO_IDX_STEP_UP, 8'h04);
      wr(`PAO_IDX_CONTROL, 8'h80);
      cnt(160);
      chk("old step", {31'h0, r >= 19 && r <= 21}, 32'h1);
      wr(`PAO_IDX_STEP_UP, 8'h00);
      wr(`PAO_IDX_STEP_HI, 8'h10);
      cnt(160);
      chk("no commit", {31'h0, r >= 19 && r <= 21}, 32'h1);
      wr(`PAO_IDX_STEP_LO, 8'h00);
      cnt(160);
      chk("commit", {31'h0, r <= 1}, 32'h1);
      $display("test commit done");
   endtask
   // Step 0x01000: one carry every 256 ticks.
   task automatic t_pulse;
      for (int w = 0; w < 8; w++) begin
         wr(`PAO_IDX_CLOCK, {w[2:0], 5'h00});
         wr(`PAO_IDX_CONTROL, 8'h81);
         repeat (800) @(posedge mclk);
         chk("width", {16'h0, lastHigh}, 32'h1 << w);
      end
      wr(`PAO_IDX_CLOCK, 8'h40);
      wr(`PAO_IDX_CONTROL, 8'h91);
      repeat (800) @(posedge mclk);
      chk("inverted", {16'h0, lastLow}, 32'h4);
      wr(`PAO_IDX_CLOCK, 8'hE0);
      wr(`PAO_IDX_CONTROL, 8'h80);
      repeat (800) @(posedge mclk);
      chk("toggle width", {16'h0, lastHigh}, 32'h100);
      $display("test pulse done");
   endtask
   task automatic t_stuck;
      wr(`PAO_IDX_STEP_UP, 8'h04);
      wr(`PAO_IDX_STEP_HI, 8'h00);
      wr(`PAO_IDX_STEP_LO, 8'h00);
      wr(`PAO_IDX_CONTROL, 8'h81);
      repeat (50) @(posedge mclk);
      cnt(200);
      chk("stuck", {16'h0, r}, 32'h0);
      rd(`PAO_IDX_CONTROL);
      chk("control", q, 32'hA1);
      $display("test stuck done");
   endtask
   task automatic t_irq;
      wr(`PAO_IDX_IRQ, 8'h02);
      repeat (20) @(posedge mclk);
      rd(`PAO_IDX_IRQ);
      chk("flag", q, 32'h03);
      chk("no request", {31'h0, irqReq}, 32'h0);
      wr(`PAO_IDX_IRQ, 8'h0F);
      chk("request", {31'h0, irqReq}, 32'h1);
      wr(`PAO_IDX_CONTROL, 8'h00);
      wr(`PAO_IDX_IRQ, 8'h0E);
      repeat (20) @(posedge mclk);
      rd(`PAO_IDX_IRQ);
      chk("cleared", q, 32'h0E);
      wr(`PAO_IDX_CONTROL, 8'h10);
      rd(`PAO_IDX_IRQ);
      chk("polarity flag", q, 32'h0F);
      chk("disabled", {31'h0, irqReq}, 32'h0);
      wr(`PAO_IDX_IRQ, 8'h00);
      $display("test interrupt done");
   endtask
   task automatic t_src;
      wr(`PAO_IDX_CLOCK, 8'h01);
      wr(`PAO_IDX_CONTROL, 8'h80);
      chk("hold on", {31'h0, fastOscHold}, 32'h1);
      wr(`PAO_IDX_CLOCK, 8'h02);
      chk("hold off", {31'h0, fastOscHold}, 32'h0);
      repeat (20) @(posedge mclk);
      cnt(640);
      chk("source 2", {31'h0, r >= 9 && r <= 11}, 32'h1);
      wr(`PAO_IDX_CLOCK, 8'h0F);
      repeat (10) @(posedge mclk);
      cnt(200);
      chk("source 15", {16'h0, r}, 32'h0);
      $display("test source done");
   endtask
   // ------------------------------------------------------------------
   // Sequence and watchdog
   // ------------------------------------------------------------------
   initial begin
      repeat (2) @(posedge mclk);
      nrst <= 1'b1;
      t_reset;
      t_regs;
      t_toggle;
      t_commit;
      t_pulse;
      t_stuck;
      t_irq;
      t_src;
      summarize;
   end
   // The whole sequence takes about 10700 cycles.
   initial begin
      #3000000;
      num_errors++;
      summarize;
   end
endmodule
